/* design/aio_cmd_parser.sv */
// Character and RTU command interpreter with Wishbone status access
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`include "aio_params.svh"
// ****************************************************************
// Summary of operation
// - Valid relay command answers greater-than then carriage return.
// - Format, checksum or address mismatch gives no answer at all.
// - Channel selector 00 sets all four relays from data bits.
// - Configuration command updates address, rate and format; stored.
// - New address is two hex characters, any byte, then adopted.
// - Rate codes 04..08 select 2400 to 38400 baud.
// - Format bit 6 enables checksum; other bits must be zero.
// - Configuration answers bang-address or question-address.
// - Rate or checksum change only in default state at 00.
// - Command 2 returns address, kind, rate and format.
// - Command M returns address and fixed module name.
// - Protocol digit 0 selects characters, 1 selects RTU.
// - Protocol change applies only in default state.
// - Override switch at power-up gives address 00, 9600 baud.
// - Character protocol after reset.
// - RTU functions 01 and 05 read and write coils.
// - RTU functions 03 and 06 read and write holding register.
// - Coil reads of inputs give one for high level.
// - Checksum is byte sum before carriage return as two hex.
// - Single channel data is only 00 or 01.
// ****************************************************************
module aio_cmd_parser #(
  parameter int unsigned GAP_CYCLES = `AIO_GAP_CYCLES,
  parameter logic [7:0] FACTORY_ADDR = `AIO_FACTORY_ADDR,
  parameter logic [31:0] NAME_STR = `AIO_NAME_STR,
  parameter int unsigned BUF_DEPTH = 16,
  parameter int unsigned REP_DEPTH = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic override_i,
  input wire logic [3:0] din_i,
  output logic [3:0] relay_o,
  output logic [7:0] station_o,
  output logic [7:0] line_rate_code_o,
  output logic [15:0] line_div_o,
  output logic [7:0] format_flags_o,
  output logic modbus_mode_o,
  output logic nv_store_o
);
  localparam int unsigned IW = $clog2(BUF_DEPTH);
  localparam int unsigned LW = IW + 1;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Upper-case hex only, lower case is a format error
  function automatic logic hex_ok(input logic [7:0] c);
    hex_ok = (c >= `AIO_CH_0 && c <= `AIO_CH_9) ||
             (c >= `AIO_CH_A && c <= `AIO_CH_F);
  endfunction
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    hex_val = (c <= `AIO_CH_9) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction
  function automatic logic [7:0] pair(input logic [7:0] h,
                                      input logic [7:0] l);
    pair = {hex_val(h), hex_val(l)};
  endfunction
  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'ha) ? 8'(`AIO_CH_0 + n) : 8'(`AIO_CH_A - 8'h0a + n);
  endfunction
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ `AIO_CRC_POLY) : (c >> 1);
    crc_step = c;
  endfunction

  // ****************************************************************
  // Pin synchronisers and start-up strap
  // ****************************************************************
  logic [1:0] ovr_sync;
  logic [3:0] din_meta;
  logic [3:0] din_lvl;
  logic [1:0] settle;
  logic default_mode;
  wire ovr_lvl = ovr_sync[1];
  // Two flops per pin before any logic looks at it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ovr_sync <= 2'h0;
      din_meta <= 4'h0;
      din_lvl <= 4'h0;
    end
    else if (ce_i)
    begin
      ovr_sync <= {ovr_sync[0], override_i};
      din_meta <= din_i;
      din_lvl <= din_meta;
    end
  end
  // Switch caught once the synchroniser has filled after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      settle <= 2'h0;
      default_mode <= 1'b0;
    end
    else if (ce_i && settle != `AIO_SETTLE)
    begin
      settle <= 2'(settle + 2'h1);
      if (settle == 2'(`AIO_SETTLE - 2'h1))
        default_mode <= ovr_lvl;
    end
  end

  // ****************************************************************
  // Receive framing
  // ****************************************************************
  aio_pkg::aio_state_t state;
  logic [7:0] cbuf [BUF_DEPTH];
  logic [LW-1:0] clen;
  logic ovf;
  logic [7:0] sum0;
  logic [7:0] sum1;
  logic [7:0] sum2;
  logic [15:0] rcrc;
  logic [31:0] gap_cnt;
  logic [7:0] station;
  logic [7:0] rate;
  logic [7:0] fmt;
  logic modbus;
  logic [3:0] relay;
  wire mb_mode = modbus && !default_mode;
  wire gap_done = gap_cnt >= GAP_CYCLES;
  wire in_rx = state == aio_pkg::AIO_HUNT || state == aio_pkg::AIO_COLLECT;
  wire rx_take = rx_valid_i && in_rx;
  wire is_lead = rx_data_i == `AIO_CH_HASH || rx_data_i == `AIO_CH_DOLLAR ||
                 rx_data_i == `AIO_CH_PCT;
  // Anything before a delimiter is dropped
  wire start_frame = rx_take && (mb_mode ? gap_done : is_lead);
  wire in_coll = rx_take && state == aio_pkg::AIO_COLLECT;
  wire end_ascii = in_coll && !mb_mode && rx_data_i == `AIO_CR;
  wire end_mb = in_coll && mb_mode && !gap_done &&
                clen == LW'(`AIO_LEN_MB - 1);
  // Silence timer marks RTU frame boundaries
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gap_cnt <= 32'h0;
    else if (ce_i)
      gap_cnt <= rx_valid_i ? 32'h0 : (gap_done ? gap_cnt : gap_cnt + 1);
  end
  // Character store with running sums; overlong lines flag overflow
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clen <= '0;
      ovf <= 1'b0;
      sum0 <= 8'h00;
      sum1 <= 8'h00;
      sum2 <= 8'h00;
      rcrc <= `AIO_CRC_INIT;
    end
    else if (ce_i && start_frame)
    begin
      cbuf[0] <= rx_data_i;
      clen <= LW'(1);
      ovf <= 1'b0;
      sum0 <= rx_data_i;
      sum1 <= 8'h00;
      sum2 <= 8'h00;
      rcrc <= crc_step(`AIO_CRC_INIT, rx_data_i);
    end
    else if (ce_i && in_coll && !end_ascii)
    begin
      if (clen == LW'(BUF_DEPTH))
        ovf <= 1'b1;
      else
      begin
        cbuf[clen[IW-1:0]] <= rx_data_i;
        clen <= LW'(clen + LW'(1));
      end
      sum2 <= sum1;
      sum1 <= sum0;
      sum0 <= 8'(sum0 + rx_data_i);
      rcrc <= crc_step(rcrc, rx_data_i);
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [10:1] hexv;
  for (genvar g = 1; g <= 10; g++)
  begin : g_hex
    assign hexv[g] = hex_ok(cbuf[g]);
  end
  wire cs_on = fmt[`AIO_FMT_CS_BIT];
  wire [LW-1:0] blen = cs_on ? LW'(clen - LW'(2)) : clen;
  wire [IW-1:0] ck_hi = IW'(clen - LW'(2));
  wire [IW-1:0] ck_lo = IW'(clen - LW'(1));
  // Received sum covers all characters ahead of the two digits
  wire cs_good = !cs_on || (clen >= LW'(2) && hex_ok(cbuf[ck_hi]) &&
                 hex_ok(cbuf[ck_lo]) && pair(cbuf[ck_hi], cbuf[ck_lo]) == sum2);
  wire [7:0] f_addr = pair(cbuf[1], cbuf[2]);
  wire [7:0] f3 = pair(cbuf[3], cbuf[4]);
  wire [7:0] f5 = pair(cbuf[5], cbuf[6]);
  wire [7:0] f7 = pair(cbuf[7], cbuf[8]);
  wire [7:0] f9 = pair(cbuf[9], cbuf[10]);
  wire [7:0] my_addr = default_mode ? `AIO_ADDR_DEF : station;
  // Bad format, bad sum or another station: stay silent
  wire lead_ok = !ovf && cs_good && hexv[1] && hexv[2] && f_addr == my_addr;
  wire rd4 = cbuf[0] == `AIO_CH_DOLLAR && blen == LW'(`AIO_LEN_RD);
  wire out_cmd = cbuf[0] == `AIO_CH_HASH && blen == LW'(`AIO_LEN_OUT) &&
                 (&hexv[6:3]);
  wire ok_all = f3 == `AIO_SEL_ALL && f5[7:4] == 4'h0;
  wire ok_one = f3[7:4] == `AIO_SEL_SINGLE && f3[3:2] == 2'h0 &&
                f5[7:1] == 7'h00;
  wire cfg_cmd = cbuf[0] == `AIO_CH_PCT && blen == LW'(`AIO_LEN_CFG) &&
                 (&hexv[10:3]);
  wire rate_ok = f7 >= `AIO_RATE_MIN && f7 <= `AIO_RATE_MAX;
  wire kind_ok = f5 == `AIO_KIND_CODE;
  wire fmt_ok = (f9 & `AIO_FMT_RSV_MASK) == 8'h00;
  wire line_chg = f7 != rate || f9[`AIO_FMT_CS_BIT] != cs_on;
  wire cfg_ok = rate_ok && kind_ok && fmt_ok &&
                (!line_chg || default_mode);
  wire prot_cmd = cbuf[0] == `AIO_CH_DOLLAR && cbuf[3] == `AIO_CH_P &&
                  blen == LW'(`AIO_LEN_PROT);
  wire prot_dig = cbuf[4] == `AIO_CH_0 || cbuf[4] == 8'(`AIO_CH_0 + 8'h1);
  // RTU fields; a good frame leaves a zero remainder
  wire [15:0] mb_start = {cbuf[2], cbuf[3]};
  wire [15:0] mb_val = {cbuf[4], cbuf[5]};
  wire mb_hit = clen == LW'(`AIO_LEN_MB) && rcrc == 16'h0000 &&
                cbuf[0] == my_addr;
  wire mb_in = mb_start >= `AIO_MB_INPUT_BASE;
  wire [3:0] coil_src = mb_in ? din_lvl : relay;
  wire [7:0] coil_mask = (mb_val[15:3] != 13'h0) ? 8'hff :
                         ~(8'hff << mb_val[2:0]);
  wire [7:0] coil_byte = 8'({4'h0, coil_src} >> mb_start[1:0]) & coil_mask;
  wire [3:0] reg_val = (mb_start == 16'h0000) ? relay :
                       ((mb_start == `AIO_MB_INPUT_BASE) ? din_lvl : 4'h0);
  logic [7:0] rep_n [REP_DEPTH];
  logic [3:0] rep_len_n;
  logic reply_n;
  logic relay_we;
  logic [3:0] relay_new;
  logic cfg_we;
  logic prot_we;
  // Build the answer body and the side effects of one command
  always_comb
  begin
    for (int i = 0; i < REP_DEPTH; i++)
      rep_n[i] = 8'h00;
    rep_len_n = 4'h0;
    reply_n = 1'b0;
    relay_we = 1'b0;
    relay_new = relay;
    cfg_we = 1'b0;
    prot_we = 1'b0;
    if (mb_mode)
    begin
      rep_n[0] = cbuf[0];
      rep_n[1] = cbuf[1];
      if (mb_hit)
        case (cbuf[1])
          `AIO_MB_RD_COIL:
          begin
            rep_n[2] = 8'h01;
            rep_n[3] = coil_byte;
            rep_len_n = 4'h4;
            reply_n = 1'b1;
          end
          `AIO_MB_RD_REG:
          begin
            rep_n[2] = 8'h02;
            rep_n[4] = {4'h0, reg_val};
            rep_len_n = 4'h5;
            reply_n = 1'b1;
          end
          `AIO_MB_WR_COIL, `AIO_MB_WR_REG:
          begin
            for (int i = 2; i < 6; i++)
              rep_n[i] = cbuf[i];
            rep_len_n = 4'h6;
            if (cbuf[1] == `AIO_MB_WR_COIL && mb_start[15:2] == 14'h0 &&
                (mb_val == `AIO_MB_COIL_ON || mb_val == 16'h0000))
            begin
              relay_new[mb_start[1:0]] = mb_val[15];
              relay_we = 1'b1;
            end
            else if (cbuf[1] == `AIO_MB_WR_REG && mb_start == 16'h0000)
            begin
              relay_new = mb_val[3:0];
              relay_we = 1'b1;
            end
            reply_n = relay_we;
          end
          default: ;
        endcase
    end
    else if (lead_ok)
    begin
      // Default answer is the refusal with the received address
      rep_n[0] = `AIO_CH_QM;
      rep_n[1] = hex_chr(f_addr[7:4]);
      rep_n[2] = hex_chr(f_addr[3:0]);
      rep_len_n = 4'h3;
      reply_n = out_cmd || cfg_cmd || prot_cmd;
      if (out_cmd && (ok_all || ok_one))
      begin
        relay_we = 1'b1;
        if (ok_all)
          relay_new = f5[3:0];
        else
          relay_new[f3[1:0]] = f5[0];
        rep_n[0] = `AIO_CH_GT;
        rep_len_n = 4'h1;
      end
      else if (cfg_cmd && cfg_ok)
      begin
        cfg_we = 1'b1;
        rep_n[0] = `AIO_CH_BANG;
        rep_n[1] = hex_chr(f3[7:4]);
        rep_n[2] = hex_chr(f3[3:0]);
      end
      else if (prot_cmd && prot_dig && default_mode)
      begin
        prot_we = 1'b1;
        rep_n[0] = `AIO_CH_BANG;
      end
      else if (rd4 && cbuf[3] == `AIO_CH_2)
      begin
        rep_n[0] = `AIO_CH_BANG;
        rep_n[3] = hex_chr(4'(`AIO_KIND_CODE >> 4));
        rep_n[4] = hex_chr(4'(`AIO_KIND_CODE));
        rep_n[5] = hex_chr(rate[7:4]);
        rep_n[6] = hex_chr(rate[3:0]);
        rep_n[7] = hex_chr(fmt[7:4]);
        rep_n[8] = hex_chr(fmt[3:0]);
        rep_len_n = 4'h9;
        reply_n = 1'b1;
      end
      else if (rd4 && cbuf[3] == `AIO_CH_M)
      begin
        rep_n[0] = `AIO_CH_BANG;
        for (int i = 0; i < 4; i++)
          rep_n[3 + i] = NAME_STR[31 - 8 * i -: 8];
        rep_len_n = 4'h7;
        reply_n = 1'b1;
      end
      else if (rd4 && cbuf[3] == `AIO_CH_6)
      begin
        rep_n[0] = `AIO_CH_BANG;
        rep_n[1] = `AIO_CH_0;
        rep_n[2] = hex_chr(relay);
        rep_n[3] = `AIO_CH_0;
        rep_n[4] = hex_chr(din_lvl);
        rep_n[5] = `AIO_CH_0;
        rep_n[6] = `AIO_CH_0;
        rep_len_n = 4'h7;
        reply_n = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Sequencer and transmitter
  // ****************************************************************
  logic [7:0] rep [REP_DEPTH];
  logic [3:0] rep_len;
  logic tx_mb;
  logic tx_cs;
  logic [3:0] tx_idx;
  logic [7:0] tsum;
  logic [15:0] tcrc;
  wire ev = state == aio_pkg::AIO_EVAL;
  wire tx_free = !tx_valid_o || tx_ready_i;
  wire [3:0] trail = tx_mb ? 4'h2 : (tx_cs ? 4'h3 : 4'h1);
  wire [3:0] tpos = 4'(tx_idx - rep_len);
  wire in_body = tx_idx < rep_len;
  wire send_last = tx_idx == 4'(rep_len + trail - 4'h1);
  // Trailer: CRC low then high, or sum digits if checksum is on, then carriage return
  wire [7:0] tx_chr = in_body ? rep[tx_idx] :
                      tx_mb ? (tpos == 4'h0 ? tcrc[7:0] : tcrc[15:8]) :
                      (tx_cs && tpos == 4'h0) ? hex_chr(tsum[7:4]) :
                      (tx_cs && tpos == 4'h1) ? hex_chr(tsum[3:0]) :
                      `AIO_CR;
  // Receive is ignored while answering; the bus is half duplex
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= aio_pkg::AIO_HUNT;
    else if (ce_i)
      case (state)
        aio_pkg::AIO_HUNT:
          if (start_frame)
            state <= aio_pkg::AIO_COLLECT;
        aio_pkg::AIO_COLLECT:
          if (end_ascii || end_mb)
            state <= aio_pkg::AIO_EVAL;
        aio_pkg::AIO_EVAL:
          state <= reply_n ? aio_pkg::AIO_SEND : aio_pkg::AIO_HUNT;
        aio_pkg::AIO_SEND:
          if (tx_free && send_last)
            state <= aio_pkg::AIO_HUNT;
        default:
          state <= aio_pkg::AIO_HUNT;
      endcase
  end
  // Answer latched at decode; sum and CRC follow the body out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      rep_len <= 4'h0;
      tx_mb <= 1'b0;
      tx_cs <= 1'b0;
      tx_idx <= 4'h0;
      tsum <= 8'h00;
      tcrc <= `AIO_CRC_INIT;
    end
    else if (ce_i)
    begin
      if (ev)
      begin
        for (int i = 0; i < REP_DEPTH; i++)
          rep[i] <= rep_n[i];
        rep_len <= rep_len_n;
        tx_mb <= mb_mode;
        tx_cs <= cs_on;
        tx_idx <= 4'h0;
        tsum <= 8'h00;
        tcrc <= `AIO_CRC_INIT;
      end
      if (state == aio_pkg::AIO_SEND && tx_free)
      begin
        tx_data_o <= tx_chr;
        tx_valid_o <= 1'b1;
        tx_idx <= 4'(tx_idx + 4'h1);
        if (in_body)
        begin
          tsum <= 8'(tsum + tx_chr);
          tcrc <= crc_step(tcrc, tx_chr);
        end
      end
      else if (tx_ready_i)
        tx_valid_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Settings, relays and Wishbone slave
  // ****************************************************************
  wire wb_req = wb_cyc_i && wb_stb_i;
  wire wb_wr = wb_req && wb_ack_o && wb_we_i;
  wire wr_cfg = wb_wr && wb_adr_i == `AIO_WB_CONFIG;
  wire wr_rel = wb_wr && wb_adr_i == `AIO_WB_RELAY && wb_sel_i[0];
  wire [7:0] rate_eff = default_mode ? `AIO_RATE_DEF : rate;
  wire [31:0] st_word = {20'h0, state != aio_pkg::AIO_HUNT, default_mode,
                         mb_mode, ovr_lvl, din_lvl, relay};
  wire [31:0] cf_word = {7'h0, modbus, fmt, rate, station};
  // Unmapped offsets read zero and are still acknowledged
  wire [31:0] rd_word = (wb_adr_i == `AIO_WB_STATUS) ? st_word :
                        (wb_adr_i == `AIO_WB_CONFIG) ? cf_word :
                        (wb_adr_i == `AIO_WB_RELAY) ? {28'h0, relay} : 32'h0;
  // Command updates take precedence over a same-cycle bus write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      station <= FACTORY_ADDR;
      rate <= `AIO_RATE_DEF;
      fmt <= 8'h00;
      modbus <= 1'b0;
    end
    else if (ce_i && ev && cfg_we)
    begin
      station <= f3;
      rate <= f7;
      fmt <= f9;
    end
    else if (ce_i && ev && prot_we)
      modbus <= cbuf[4][0];
    else if (ce_i && wr_cfg)
    begin
      station <= wb_sel_i[0] ? wb_dat_i[7:0] : station;
      rate <= wb_sel_i[1] ? wb_dat_i[15:8] : rate;
      fmt <= wb_sel_i[2] ? wb_dat_i[23:16] : fmt;
      modbus <= wb_sel_i[3] ? wb_dat_i[24] : modbus;
    end
  end
  // Relay image
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      relay <= 4'h0;
    else if (ce_i && ev && relay_we)
      relay <= relay_new;
    else if (ce_i && wr_rel)
      relay <= wb_dat_i[3:0];
  end
  // Registered outputs; rate code selects the bit period
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      relay_o <= 4'h0;
      station_o <= FACTORY_ADDR;
      line_rate_code_o <= `AIO_RATE_DEF;
      line_div_o <= 16'(`AIO_BAUD_DIV(9600));
      format_flags_o <= 8'h00;
      modbus_mode_o <= 1'b0;
      nv_store_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req && !wb_ack_o;
      wb_dat_o <= rd_word;
      relay_o <= relay;
      station_o <= station;
      line_rate_code_o <= rate_eff;
      case (rate_eff)
        8'h04: line_div_o <= 16'(`AIO_BAUD_DIV(2400));
        8'h05: line_div_o <= 16'(`AIO_BAUD_DIV(4800));
        8'h07: line_div_o <= 16'(`AIO_BAUD_DIV(19200));
        8'h08: line_div_o <= 16'(`AIO_BAUD_DIV(38400));
        default: line_div_o <= 16'(`AIO_BAUD_DIV(9600));
      endcase
      format_flags_o <= fmt;
      modbus_mode_o <= mb_mode;
      nv_store_o <= ev && (cfg_we || prot_we);
    end
  end
endmodule

/* design/aio_params.svh */
// Named constants for the four-in, four-relay command interpreter
`ifndef AIO_PARAMS_SVH
`define AIO_PARAMS_SVH
// Clock and timing
`define AIO_CLK_HZ 100000000
`define AIO_CLK_PER_NS 10
`define AIO_FRAME_GAP_NS 4000000
`define AIO_GAP_CYCLES (`AIO_FRAME_GAP_NS / `AIO_CLK_PER_NS)
`define AIO_SETTLE 2'h3
// Characters
`define AIO_CR 8'h0d
`define AIO_CH_GT 8'h3e
`define AIO_CH_BANG 8'h21
`define AIO_CH_QM 8'h3f
`define AIO_CH_HASH 8'h23
`define AIO_CH_DOLLAR 8'h24
`define AIO_CH_PCT 8'h25
`define AIO_CH_0 8'h30
`define AIO_CH_2 8'h32
`define AIO_CH_6 8'h36
`define AIO_CH_9 8'h39
`define AIO_CH_A 8'h41
`define AIO_CH_F 8'h46
`define AIO_CH_M 8'h4d
`define AIO_CH_P 8'h50
// Command lengths without checksum and carriage return; the RTU length counts its two CRC bytes
`define AIO_LEN_OUT 7
`define AIO_LEN_CFG 11
`define AIO_LEN_RD 4
`define AIO_LEN_PROT 5
`define AIO_LEN_MB 8
// Field values
`define AIO_KIND_CODE 8'h00
`define AIO_RATE_MIN 8'h04
`define AIO_RATE_MAX 8'h08
`define AIO_RATE_DEF 8'h06
`define AIO_FMT_CS_BIT 6
`define AIO_FMT_RSV_MASK 8'hbf
`define AIO_ADDR_DEF 8'h00
`define AIO_FACTORY_ADDR 8'h01
`define AIO_SEL_ALL 8'h00
`define AIO_SEL_SINGLE 4'h1
// Arbitrary neutral module name, four characters
`define AIO_NAME_STR 32'h41494f34
// Line rates
`define AIO_BAUD_DIV(b) (`AIO_CLK_HZ / (b))
// RTU
`define AIO_MB_RD_COIL 8'h01
`define AIO_MB_RD_REG 8'h03
`define AIO_MB_WR_COIL 8'h05
`define AIO_MB_WR_REG 8'h06
`define AIO_MB_COIL_ON 16'hff00
`define AIO_MB_INPUT_BASE 16'h0020
`define AIO_CRC_INIT 16'hffff
`define AIO_CRC_POLY 16'ha001
// Wishbone byte offsets
`define AIO_WB_STATUS 8'h00
`define AIO_WB_CONFIG 8'h04
`define AIO_WB_RELAY 8'h08
`endif

/* design/aio_pkg.sv */
// Types for the command interpreter
package aio_pkg;
  typedef enum logic [1:0] {
    AIO_HUNT = 2'b00,
    AIO_COLLECT = 2'b01,
    AIO_EVAL = 2'b11,
    AIO_SEND = 2'b10
  } aio_state_t;
endpackage

/* verif/aio_cmd_parser_sva.sv */
// Port-level checks on the command interpreter
// ****************************************************************
// Checker
// ****************************************************************
module aio_cmd_parser_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic [3:0] relay_o,
  input wire logic [7:0] line_rate_code_o,
  input wire logic [15:0] line_div_o,
  input wire logic modbus_mode_o,
  input wire logic nv_store_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus request not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  // Relay pins and the greater-than byte leave their flops together
  sequence s_gt_sent;
    tx_valid_o && tx_data_o == 8'h3e;
  endsequence
  a_ack_answer:
    assert property (s_req |=> wb_ack_o) else $error("no ack");
  a_ack_pulse:
    assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("long ack");
  a_tx_hold:
    assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o)) else $error("tx dropped");
  a_relay_after_gt:
    assert property ($changed(relay_o) && !$past(wb_ack_o, 2) &&
      !modbus_mode_o
      |-> s_gt_sent) else $error("relay without answer");
  a_answer_ends_cr:
    assert property ($fell(tx_valid_o) && !modbus_mode_o
      |-> $past(tx_data_o) == 8'h0d) else $error("no final cr");
  a_eval_after_cr:
    assert property ($rose(tx_valid_o) && !modbus_mode_o |->
      $past(rx_valid_i, 3) && $past(rx_data_i, 3) == 8'h0d)
      else $error("answer before cr");
  a_rate_div:
    assert property (line_rate_code_o == 8'h06 |-> line_div_o == 16'h28b0)
      else $error("wrong divisor");
  a_nv_pulse:
    assert property (nv_store_o && ce_i |=> !nv_store_o)
      else $error("long store");
  a_reset_char:
    assert property ($fell(rst_i) |-> !modbus_mode_o && relay_o == 4'h0)
      else $error("bad reset state");
endmodule
bind aio_cmd_parser aio_cmd_parser_sva aio_cmd_parser_sva_i (.clk_i,
  .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_valid_i, .rx_data_i,
  .tx_valid_o, .tx_data_o, .tx_ready_i, .relay_o, .line_rate_code_o,
  .line_div_o, .modbus_mode_o, .nv_store_o);

/* verif/aio_host.sv */
// Host model on the serial side of the interpreter
module aio_host (
  input wire logic clk_i,
  input wire logic slow_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h55;
    tx_ready_o = 1'b1;
  end
  // A slow host takes an answer byte only every other cycle
  always @(posedge clk_i)
    tx_ready_o <= !slow_i || !tx_ready_o;
  // Upper case line closed by cr; idle data is scrambled, not held
  task automatic snd(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= (i == s.len()) ? 8'h0d : s[i];
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~rx_data_o;
    end
  endtask
endmodule

/* verif/tb_aio_cmd_parser.sv */
// Self-checking bench for the command interpreter
module tb_aio_cmd_parser;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic override_i = 0, slow = 0, wb_ack_o, rx_valid_i, tx_valid_o;
  logic tx_ready_i, modbus_mode_o, nv_store_o;
  logic [7:0] wb_adr_i = 8'h00, rx_data_i, tx_data_o, station_o, hc;
  logic [7:0] line_rate_code_o, format_flags_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rnd = 32'h0001802f;
  logic [3:0] din_i = 4'h0, relay_o;
  logic [15:0] line_div_o;
  logic [31:0] tq[$], wq[$];
  int err_count = 0, num_checks = 0;
  aio_cmd_parser #(.GAP_CYCLES(20)) aio_cmd_parser_i (.clk_i, .rst_i,
    .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_valid_i, .rx_data_i, .tx_valid_o,
    .tx_data_o, .tx_ready_i, .override_i, .din_i, .relay_o, .station_o,
    .line_rate_code_o, .line_div_o, .format_flags_o, .modbus_mode_o,
    .nv_store_o);
  aio_host aio_host_i (.clk_i, .slow_i(slow), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i));
  initial forever #5 clk_i = ~clk_i;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Oldest note meets each answer byte or read word; a stray byte fails
  always @(posedge clk_i)
  begin
    if (tx_valid_o && tx_ready_i)
      cmp("tx byte", tq.size() ? tq.pop_front() : 32'h1ff, tx_data_o);
    if (wb_ack_o && !wb_we_i)
      cmp("wb read", wq.pop_front(), wb_dat_o);
  end
  // Single classic cycle; a read notes its expected word first
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (!w)
      wq.push_back(d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
    if (n == 50)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // Send a line, then wait a bounded time for the whole answer
  task automatic cmd(input string c, input string r);
    int n;
    n = 0;
    foreach (r[i])
      tq.push_back(r[i]);
    if (r.len())
      tq.push_back(8'h0d);
    aio_host_i.snd(c);
    while (tq.size() && n++ < 3000)
      @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    if (n > 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    repeat (4) @(posedge clk_i);
    wb(0, 8'h04, 32'h00000601);
    wb(0, 8'h0c, 32'h0);
    cmd("#010002", ">");
    cmp("relay", 4'h2, relay_o);
    cmd("#011201", ">");
    cmp("relay", 4'h6, relay_o);
    cmd("#020005", "");
    cmp("relay", 4'h6, relay_o);
    repeat (3)
    begin
      rnd = xs(rnd);
      din_i <= rnd[7:4];
      hc = rnd[3:0] < 10 ? 8'h30 + rnd[3:0] : 8'h37 + rnd[3:0];
      cmd($sformatf("#01000%c", hc), ">");
      wb(0, 8'h00, {24'h0, rnd[7:0]});
    end
    wb(1, 8'h08, 32'h5);
    wb(0, 8'h08, 32'h5);
    slow <= 1;
    cmd("$012", "!01000600");
    cmd("$01M", "!01AIO4");
    cmd("%0101000800", "?01");
    cmd("$01P1", "?01");
    cmd("%0122000600", "!22");
    cmp("station", 8'h22, station_o);
    override_i <= 1;
    rst_i <= 1;
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    repeat (4) @(posedge clk_i);
    cmp("rate", 8'h06, line_rate_code_o);
    cmd("$00P1", "!00");
    wb(0, 8'h04, 32'h01000601);
    cmd("%0001000640", "!01");
    cmp("format", 8'h40, format_flags_o);
    cmd("$002B6", "!00000640AB");
    tally_and_finish();
  end
endmodule
